// >>> rtl/tcd_clock_dist.sv
// transceiver clock distribution: reference select, plls, divider, fabric routing
// How it works
// - one shared transmit pll and four per-channel receive plls
// - transmit pll makes serial clock at half the line rate
// - serial clock halved before the divider when byte serializer is used
// - divider splits its input by a mode ratio into the parallel clock
// - parallel clock forwarded on transmit clock out or shared core clock out
// - each receive pll with recovery unit gives serial and parallel recovered clocks
// - with rate matcher, early stages recovered clock, later stages divider clock
// - without rate matcher all receive stages use recovered parallel clock
// - either dedicated reference pin of the block selectable as reference
// - reference also selectable from peer block reference lines
// - at most sixteen global and sixteen regional lines carry these clocks
// - recovered clock reaches fabric only for channels without rate matcher
// - every recovered clock forwarded to the fabric passes through a route channel
// - at most eight clock paths per route region and per block
`timescale 1ns/100ps
module tcd_clock_dist
  import tcd_pkg::*;
#(
  parameter int CHANNELS = TCD_CHANNELS,
  parameter int ROUTE_PATHS = TCD_ROUTE_PATHS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cfg_load,
  input wire tcd_pkg::tcd_ref_sel_t cfg_ref_sel,
  input wire logic cfg_peer_idx,
  input wire logic [tcd_pkg::TCD_MULT_W-1:0] cfg_mult,
  input wire logic [tcd_pkg::TCD_RATIO_W-1:0] cfg_ratio,
  input wire logic cfg_byte_ser,
  input wire logic cfg_core_clk,
  input wire logic [CHANNELS-1:0] cfg_rate_match,
  input wire logic [CHANNELS-1:0] cfg_route_req,
  input wire logic enable,
  input wire logic dedicated_reference_pin_a,
  input wire logic dedicated_reference_pin_b,
  input wire logic fabric_ref_from_pin,
  input wire logic [tcd_pkg::TCD_PEER_BLOCKS-1:0] peer_ref,
  input wire logic [CHANNELS-1:0] rx_edge,
  output logic tx_parallel_clk,
  output logic core_clk,
  output logic tx_serial_clk,
  output logic [CHANNELS-1:0] rx_serial_clk,
  output logic [CHANNELS-1:0] rx_parallel_clk,
  output logic [CHANNELS-1:0] rx_front_clk,
  output logic [CHANNELS-1:0] rx_back_clk,
  output logic [CHANNELS-1:0] fabric_recovered_clk,
  output logic [CHANNELS-1:0] route_grant,
  output logic [4:0] global_lines_used,
  output logic running,
  output logic cfg_refused
);
  import tcd_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // configuration held while channels run

  tcd_ref_sel_t ref_sel;
  logic peer_idx;
  logic [TCD_MULT_W-1:0] mult;
  logic [TCD_RATIO_W-1:0] ratio;
  logic byte_ser;
  logic core_sel;
  logic [CHANNELS-1:0] rate_match;
  tcd_state_t state;
  tcd_state_t next_state;

  // loads only while idle; a change mid-run would glitch every channel clock
  wire load_ok = cfg_load & (state == tcd_st_idle);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ref_sel <= tcd_ref_pin_a;
      peer_idx <= 1'b0;
      mult <= TCD_MULT_RESET;
      ratio <= TCD_RATIO_RESET;
      byte_ser <= 1'b0;
      core_sel <= 1'b0;
      rate_match <= '0;
    end else if (load_ok) begin
      ref_sel <= cfg_ref_sel;
      peer_idx <= cfg_peer_idx;
      mult <= cfg_mult;
      ratio <= cfg_ratio;
      byte_ser <= cfg_byte_ser;
      core_sel <= cfg_core_clk;
      rate_match <= cfg_rate_match;
    end
  end

  // refusal flag: a load attempt while locking or running
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_refused <= 1'b0;
    end else begin
      cfg_refused <= cfg_load & (state != tcd_st_idle);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reference selection

  // fabric source counts only when it comes straight from a clock pin
  wire fabric_ok = fabric_ref_from_pin;
  wire peer_ref_sel = peer_ref[peer_idx];
  wire ref_mux = (ref_sel == tcd_ref_pin_a) ? dedicated_reference_pin_a :
    (ref_sel == tcd_ref_pin_b) ? dedicated_reference_pin_b :
    (ref_sel == tcd_ref_fabric) ? fabric_ok : peer_ref_sel;
  logic ref_d;
  wire ref_rise = ref_mux & ~ref_d;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ref_d <= 1'b0;
    end else begin
      ref_d <= ref_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // run control: lock after the first reference rising edge

  logic [TCD_MULT_W-1:0] mcount;
  wire mlast = (mcount >= mult - 6'h01) | (mult == 6'h00);

  always_comb begin
    next_state = state;
    case (state)
      tcd_st_idle: if (enable) next_state = tcd_st_lock;
      tcd_st_lock: if (!enable) next_state = tcd_st_idle;
        else if (ref_rise) next_state = tcd_st_run;
      tcd_st_run: if (!enable) next_state = tcd_st_idle;
      default: next_state = tcd_st_idle;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= tcd_st_idle;
      running <= 1'b0;
    end else begin
      state <= next_state;
      running <= (next_state == tcd_st_run);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // single shared transmit pll model: one serial tick every mult clock cycles once locked

  // one tick per mult cycles stands for one serial clock edge at half line rate
  wire serial_tick = (state == tcd_st_run) & mlast;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mcount <= 6'h00;
      tx_serial_clk <= 1'b0;
    end else if (state != tcd_st_run) begin
      mcount <= 6'h00;
      tx_serial_clk <= 1'b0;
    end else begin
      mcount <= mlast ? 6'h00 : mcount + 6'h01;
      tx_serial_clk <= tx_serial_clk ^ serial_tick;
    end
  end

  tcd_div_if dvi ();
  assign dvi.run = (state == tcd_st_run);
  assign dvi.byte_ser = byte_ser;
  assign dvi.ratio = ratio;
  assign dvi.serial_tick = serial_tick;

  tcd_cmu_div u_div (
    .clock(clock),
    .rst_n(rst_n),
    .dv(dvi)
  );

  // parallel clock out to fabric on one of two ports
  wire par_tick = dvi.parallel_tick;
  logic par_clk;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      par_clk <= 1'b0;
      tx_parallel_clk <= 1'b0;
      core_clk <= 1'b0;
    end else begin
      par_clk <= par_clk ^ par_tick;
      tx_parallel_clk <= ~core_sel & (par_clk ^ par_tick);
      core_clk <= core_sel & (par_clk ^ par_tick);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // four receive plls with clock recovery

  logic [CHANNELS-1:0] rx_ser;
  logic [CHANNELS-1:0] rx_par;
  logic [TCD_RATIO_W-1:0] rcount [CHANNELS];
  wire [CHANNELS-1:0] rx_tick = rx_edge & {CHANNELS{state == tcd_st_run}};
  wire par_next = par_clk ^ par_tick;

  // route paths granted in channel order, capped per block and region
  function automatic logic [CHANNELS-1:0] grant_paths(input logic [CHANNELS-1:0] req,
    input int limit);
    int n;
    grant_paths = '0;
    n = 0;
    for (int i = 0; i < CHANNELS; i++) begin
      if (req[i] && n < limit) begin
        grant_paths[i] = 1'b1;
        n = n + 1;
      end
    end
  endfunction

  // recovered clocks need a line only without rate matcher, through a route path
  wire [CHANNELS-1:0] want_route = cfg_route_req & ~rate_match;
  wire [CHANNELS-1:0] granted = grant_paths(want_route,
    (ROUTE_PATHS - 1 < TCD_GLOBAL_LINES) ? ROUTE_PATHS - 1 : TCD_GLOBAL_LINES);

  function automatic logic [4:0] pop(input logic [CHANNELS-1:0] v);
    pop = 5'h00;
    for (int i = 0; i < CHANNELS; i++) begin
      pop = pop + {4'h0, v[i]};
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_rx
      wire rlast = (rcount[g] == ratio - 4'h1) | (ratio == 4'h0);
      wire rpar_next = rx_par[g] ^ (rx_tick[g] & rlast);

      // recovered serial and parallel clocks per channel
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          rx_ser[g] <= 1'b0;
          rx_par[g] <= 1'b0;
          rcount[g] <= 4'h0;
        end else if (state != tcd_st_run) begin
          rx_ser[g] <= 1'b0;
          rx_par[g] <= 1'b0;
          rcount[g] <= 4'h0;
        end else begin
          rx_ser[g] <= rx_ser[g] ^ rx_tick[g];
          rx_par[g] <= rpar_next;
          if (rx_tick[g]) begin
            rcount[g] <= rlast ? 4'h0 : rcount[g] + 4'h1;
          end
        end
      end

      // stage clocks and fabric forwarding
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          rx_front_clk[g] <= 1'b0;
          rx_back_clk[g] <= 1'b0;
          fabric_recovered_clk[g] <= 1'b0;
        end else begin
          rx_front_clk[g] <= rpar_next;
          rx_back_clk[g] <= rate_match[g] ? par_next : rpar_next;
          fabric_recovered_clk[g] <= granted[g] & rpar_next;
        end
      end
    end
  endgenerate

  // serial/parallel copies, grants and line usage; one line kept for the tx clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rx_serial_clk <= '0;
      rx_parallel_clk <= '0;
      route_grant <= '0;
      global_lines_used <= 5'h00;
    end else begin
      rx_serial_clk <= rx_ser;
      rx_parallel_clk <= rx_par;
      route_grant <= granted;
      global_lines_used <= pop(granted) + 5'h01;
    end
  end
endmodule

// >>> rtl/tcd_pkg.sv
// constants and types shared by the transceiver clock distribution block
package tcd_pkg;
  localparam int TCD_CHANNELS = 4;
  localparam int TCD_PEER_BLOCKS = 2;
  localparam int TCD_GLOBAL_LINES = 16;
  localparam int TCD_REGIONAL_LINES = 16;
  localparam int TCD_ROUTE_PATHS = 8;
  localparam int TCD_RATIO_W = 4;
  localparam int TCD_MULT_W = 6;
  localparam logic [TCD_RATIO_W-1:0] TCD_RATIO_RESET = 4'h5;
  localparam logic [TCD_MULT_W-1:0] TCD_MULT_RESET = 6'h04;
  localparam int TCD_REF_SEL_W = 2;
  localparam int TCD_CLOCK_MHZ = 25;
  localparam real TCD_CLOCK_NS = 40.0;

  // reference source choices for the transmit and receive plls
  typedef enum logic [TCD_REF_SEL_W-1:0] {
    tcd_ref_pin_a,
    tcd_ref_pin_b,
    tcd_ref_fabric,
    tcd_ref_peer
  } tcd_ref_sel_t;

  typedef enum logic [1:0] {
    tcd_st_idle,
    tcd_st_lock,
    tcd_st_run
  } tcd_state_t;
endpackage

// >>> rtl/tcd_div_if.sv
// carrier between the top and the clock management unit divider
`timescale 1ns/100ps
interface tcd_div_if;
  import tcd_pkg::*;
  logic run;
  logic byte_ser;
  logic [TCD_RATIO_W-1:0] ratio;
  logic serial_tick;
  logic parallel_tick;
  modport top (output run, output byte_ser, output ratio, output serial_tick,
    input parallel_tick);
  modport div (input run, input byte_ser, input ratio, input serial_tick,
    output parallel_tick);
endinterface

// >>> rtl/tcd_cmu_div.sv
// clock management unit divider: optional halving then ratio division
`timescale 1ns/100ps
module tcd_cmu_div
  import tcd_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  tcd_div_if.div dv
);
  logic half;
  logic [TCD_RATIO_W-1:0] count;
  wire div_in = dv.serial_tick & (~dv.byte_ser | half);
  wire last = (count == dv.ratio - 4'h1) | (dv.ratio == 4'h0);
  logic pulse;

  // halving stage before the divider, cleared when stopped so every run starts in phase
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      half <= 1'b0;
    end else if (!dv.run) begin
      half <= 1'b0;
    end else if (dv.serial_tick) begin
      half <= ~half;
    end
  end

  // ratio counter, cleared while not running so phase starts clean
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= 4'h0;
      pulse <= 1'b0;
    end else if (!dv.run) begin
      count <= 4'h0;
      pulse <= 1'b0;
    end else begin
      pulse <= div_in & last;
      if (div_in) begin
        count <= last ? 4'h0 : count + 4'h1;
      end
    end
  end

  assign dv.parallel_tick = pulse;
endmodule

// >>> tb/tcd_clock_dist_chk.sv
// assertions on the ports of the clock distribution top
`timescale 1ns/100ps
module tcd_clock_dist_chk
  import tcd_pkg::*;
#(
  parameter int CHANNELS = TCD_CHANNELS,
  parameter int ROUTE_PATHS = TCD_ROUTE_PATHS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cfg_load,
  input wire logic enable,
  input wire logic [CHANNELS-1:0] cfg_rate_match,
  input wire logic [CHANNELS-1:0] rx_parallel_clk,
  input wire logic [CHANNELS-1:0] rx_back_clk,
  input wire logic [CHANNELS-1:0] rx_front_clk,
  input wire logic tx_parallel_clk,
  input wire logic core_clk,
  input wire logic [CHANNELS-1:0] fabric_recovered_clk,
  input wire logic [CHANNELS-1:0] route_grant,
  input wire logic [4:0] global_lines_used,
  input wire logic running,
  input wire logic cfg_refused
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  // reloading mid-run would move clocks under live channels, so it is refused
  refuse_load_a: assert property (cfg_load && running |=> cfg_refused)
    else $error("load while running not refused");
  refuse_cause_a: assert property (cfg_refused |-> $past(cfg_load))
    else $error("refusal without a load");
  stop_run_a: assert property (running && !enable |=> !running)
    else $error("running held after disable");
  start_run_a: assert property ($rose(running) |-> $past(enable))
    else $error("running rose without enable");
  recov_route_a: assert property ((fabric_recovered_clk & ~route_grant) == '0)
    else $error("recovered clock without route path");
  no_rm_grant_a: assert property (running |-> (route_grant & cfg_rate_match) == '0)
    else $error("grant on rate matched channel");
  grant_limit_a: assert property ($countones(route_grant) <= ROUTE_PATHS - 1)
    else $error("too many route grants");
  lines_count_a: assert property (running |->
      global_lines_used == $countones(route_grant) + 1)
    else $error("global line count wrong");
  // without a rate matcher the back stages share the front stages' recovered clock
  back_clock_a: assert property (running |->
      ((rx_back_clk ^ rx_front_clk) & ~cfg_rate_match) == '0)
    else $error("back stages off recovered clock");
  // with a rate matcher the back stages follow the forwarded divider clock
  back_divider_a: assert property (running |->
      ((rx_back_clk ^ {CHANNELS{tx_parallel_clk | core_clk}}) & cfg_rate_match) == '0)
    else $error("back stages off divider clock");
endmodule

bind tcd_clock_dist tcd_clock_dist_chk #(.CHANNELS(CHANNELS), .ROUTE_PATHS(ROUTE_PATHS)) i_chk (
  .clock(clock), .rst_n(rst_n), .cfg_load(cfg_load), .enable(enable),
  .cfg_rate_match(cfg_rate_match), .rx_parallel_clk(rx_parallel_clk),
  .rx_back_clk(rx_back_clk), .rx_front_clk(rx_front_clk),
  .tx_parallel_clk(tx_parallel_clk), .core_clk(core_clk),
  .fabric_recovered_clk(fabric_recovered_clk),
  .route_grant(route_grant), .global_lines_used(global_lines_used),
  .running(running), .cfg_refused(cfg_refused));

// >>> tb/tcd_fabric_model.sv
// fabric side model: reference clock sources and recovered bit pulses
`timescale 1ns/100ps
module tcd_fabric_model (
  input wire logic clock,
  input wire logic [3:0] hold,
  output logic ref_a,
  output logic ref_b,
  output logic ref_fab,
  output logic [1:0] ref_peer,
  output logic [3:0] rx_edge
);
  logic [2:0] cnt = 3'h0;
  ////////////////////////////////////////////////////////////////////////
  // hold keeps a source low so the bench can prove which one is listened to
  always @(posedge clock) begin
    cnt <= cnt + 3'h1;
    ref_a <= cnt[1] & ~hold[0];
    ref_b <= cnt[1] & ~hold[1];
    ref_fab <= cnt[1] & ~hold[2];
    ref_peer <= {2{cnt[1] & ~hold[3]}};
    rx_edge <= {cnt[0], ~cnt[0], cnt[0], ~cnt[0]};
  end
endmodule

// >>> tb/transceiver_clock_distribution_tb.sv
// self-checking bench for the transceiver clock distribution top
`timescale 1ns/100ps
module transceiver_clock_distribution_tb;
  import tcd_pkg::*;
  logic clock = 0, rst_n = 0, cfg_load = 0, cfg_peer_idx = 0, cfg_byte_ser = 0;
  logic cfg_core_clk = 0, enable = 0, ref_a, ref_b, ref_fab, tx_par, core_clk, tx_ser;
  tcd_ref_sel_t cfg_ref_sel = tcd_ref_pin_a;
  logic [5:0] cfg_mult = 6'h01;
  logic [3:0] cfg_ratio = 4'h1, cfg_rate_match = 4'h0, hold = 4'h0, grant, rx_par, rx_edge;
  logic [3:0] route_req = 4'hf, rx_sr;
  logic [1:0] ref_peer;
  logic [4:0] lines;
  logic running, refused, ps, pp, pr, pi;
  int ts, tp, tr, ti, cycles = 0, mismatches = 0, tests_run = 0;
  always #20 clock = ~clock;
  tcd_fabric_model i_fab (.clock(clock), .hold(hold), .ref_a(ref_a), .ref_b(ref_b),
    .ref_fab(ref_fab), .ref_peer(ref_peer), .rx_edge(rx_edge));
  tcd_clock_dist #(.ROUTE_PATHS(3)) i_dut (.clock(clock), .rst_n(rst_n),
    .cfg_load(cfg_load), .cfg_ref_sel(cfg_ref_sel), .cfg_peer_idx(cfg_peer_idx),
    .cfg_mult(cfg_mult), .cfg_ratio(cfg_ratio), .cfg_byte_ser(cfg_byte_ser),
    .cfg_core_clk(cfg_core_clk), .cfg_rate_match(cfg_rate_match), .cfg_route_req(route_req),
    .enable(enable), .dedicated_reference_pin_a(ref_a), .dedicated_reference_pin_b(ref_b),
    .fabric_ref_from_pin(ref_fab), .peer_ref(ref_peer), .rx_edge(rx_edge),
    .tx_parallel_clk(tx_par), .core_clk(core_clk), .tx_serial_clk(tx_ser),
    .rx_serial_clk(rx_sr), .rx_parallel_clk(rx_par), .rx_front_clk(), .rx_back_clk(),
    .fabric_recovered_clk(), .route_grant(grant), .global_lines_used(lines),
    .running(running), .cfg_refused(refused));
  ////////////////////////////////////////////////////////////////////////
  // toggle counters sampled mid-cycle, away from the launching edge
  always @(negedge clock) begin
    ts += (tx_ser != ps);
    tp += ((cfg_core_clk ? core_clk : tx_par) != pp);
    tr += (rx_par[0] != pr);
    ti += (rx_sr[0] != pi);
    pi = rx_sr[0];
    ps = tx_ser;
    pp = cfg_core_clk ? core_clk : tx_par;
    pr = rx_par[0];
  end
  // a hang is cut short well beyond the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
      mismatches++;
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // toggle counts are allowed one count of slack for the phase at the start
  task automatic near(input string what, input int exp, input int got);
    tests_run++;
    if (got < exp - 1 || got > exp + 1) begin
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
      mismatches++;
    end
  endtask
  task automatic measure(input int n);
    @(posedge clock);
    ts = 0;
    tp = 0;
    tr = 0;
    ti = 0;
    repeat (n) @(posedge clock);
  endtask
  // load while idle, start with the chosen source held, then let it run
  task automatic bring_up(input logic [1:0] sel, input logic [5:0] m, input logic [3:0] r,
      input logic bs, input logic [3:0] rm);
    int i;
    @(posedge clock);
    enable <= 0;
    hold <= 4'h1 << sel;
    repeat (3) @(posedge clock);
    cfg_ref_sel <= tcd_ref_sel_t'(sel);
    cfg_peer_idx <= sel[0];
    cfg_core_clk <= sel[0];
    cfg_mult <= m;
    cfg_ratio <= r;
    cfg_byte_ser <= bs;
    cfg_rate_match <= rm;
    cfg_load <= 1;
    @(posedge clock);
    cfg_load <= 0;
    enable <= 1;
    repeat (12) @(negedge clock);
    check("run on held source", 8'h0, running);
    @(posedge clock);
    hold <= 4'h0;
    i = 0;
    while (running !== 1'b1 && i < 20) begin
      @(negedge clock);
      i++;
    end
    check("running", 8'h1, running);
  endtask
  task automatic t_reset();
    @(negedge clock);
    check("running at reset", 8'h0, running);
    check("grants at reset", 8'h0, grant);
  endtask
  // every reference source, clock forwarded alternately on both outputs
  task automatic t_sources();
    for (int s = 0; s < 4; s++) begin
      bring_up(2'(s), 6'h01, 4'h2, 1'b0, 4'h5);
      measure(64);
      near("serial toggles", 64, ts);
      near("parallel toggles", 32, tp);
      check("recovered toggles", 8'h1, 8'(tr > 0));
      near("recovered serial toggles", 32, ti);
      check("grants", 8'h0a, grant);
      check("global lines", 8'h03, lines);
    end
  endtask
  // byte serializer halves the divider input; grants capped by route paths
  task automatic t_divider();
    for (int b = 0; b < 2; b++) begin
      route_req <= b ? 4'hc : 4'hf;
      bring_up(2'h0, 6'h03, 4'h5, b[0], 4'h0);
      measure(120);
      near("serial toggles", 40, ts);
      near("parallel toggles", b ? 4 : 8, tp);
      check("grant count", 8'h2, 8'($countones(grant)));
      check("grants", b ? 8'h0c : 8'h03, grant);
    end
  endtask
  // a load while running is refused for one cycle; disable stops the run
  task automatic t_refuse();
    @(posedge clock);
    cfg_load <= 1;
    @(posedge clock);
    cfg_load <= 0;
    @(negedge clock);
    check("refused", 8'h1, refused);
    @(negedge clock);
    check("refused pulse", 8'h0, refused);
    @(posedge clock);
    enable <= 0;
    repeat (2) @(negedge clock);
    check("stopped", 8'h0, running);
  endtask
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1;
    t_reset();
    t_sources();
    t_divider();
    t_refuse();
    final_report();
  end
endmodule
